//--- verilog/crtfb_pkg.sv
// Package for the frame-buffer and CRT side of a CRT display controller.
// Assumes one operating clock at twice the dot clock feeds every user of it.
package crtfb_pkg;

	// Scan modes: non-interlaced, interlace sync, interlace sync and video
	typedef enum logic [1:0] {SCAN_NI, SCAN_IS, SCAN_ISV} crtfb_scan_t;
	// Logical screen control: disabled, shown, blanked
	typedef enum logic [1:0] {SCR_OFF, SCR_ON, SCR_BLANK} crtfb_scr_t;
	// Cursor mode: off, steady, blinking
	typedef enum logic [1:0] {CUR_OFF, CUR_ON, CUR_BLINK} crtfb_cur_t;
	// Kind of the memory access under way
	typedef enum logic [1:0] {ACC_IDLE, ACC_REF, ACC_DRAW} crtfb_acc_t;

	// Display setup, held stable by the user while the screen runs
	typedef struct packed {
		logic [12:0] hpix;
		logic [2:0] depth;
		logic [7:0] htotal;
		logic [7:0] hs_start;
		logic [7:0] hs_width;
		logic [11:0] vdisp;
		logic [11:0] vtotal;
		logic [11:0] vs_start;
		logic [3:0] vs_width;
		logic [4:0] row_last;
		logic [4:0] cur_top;
		logic [4:0] cur_bot;
		logic [11:0] mem_width;
		logic [19:0] start_addr;
		logic [19:0] cur_a_addr;
		logic [19:0] cur_b_addr;
		logic chr_mode;
		crtfb_scan_t scan;
		crtfb_scr_t scr_a;
		crtfb_scr_t scr_b;
		crtfb_cur_t cur_mode;
		logic sync_drive;
	} crtfb_cfg_t;

	// Drawing access request, held until acknowledged
	typedef struct packed {
		logic valid;
		logic write;
		logic [19:0] addr;
		logic [15:0] wdata;
	} crtfb_drw_t;

	// Frame-buffer pins
	typedef struct packed {
		logic [15:0] mad;
		logic mad_oe;
		logic fb_address_strobe_n;
		logic [3:0] upper_addr_raster_lines;
		logic raster_bit_top;
		logic chr;
		logic mcyc;
		logic mrd;
		logic draw_n;
	} crtfb_fb_t;

	// CRT pins
	typedef struct packed {
		logic hsync_n;
		logic vsync_n;
		logic screen_enable_a;
		logic screen_enable_b;
		logic cursor_out_a;
		logic cursor_out_b;
	} crtfb_crt_t;

	// Whole state of the core
	typedef struct packed {
		crtfb_acc_t acc;
		logic dwr;
		logic [15:0] dwdata;
		logic [7:0] hcnt;
		logic [11:0] vcnt;
		logic [4:0] ras;
		logic field;
		logic [4:0] frame;
		logic [19:0] row_addr;
		logic [19:0] ref_addr;
		logic [19:0] lp_addr;
		logic lp_valid;
		logic ack;
		logic [15:0] rdata;
		logic [2:0] lp_sync;
		logic [2:0] ex_sync;
		crtfb_fb_t fb;
		crtfb_crt_t crt;
	} crtfb_st_t;

	// Values after reset
	localparam crtfb_fb_t FB_RST = '{fb_address_strobe_n: 1'b1, mcyc: 1'b1, mrd: 1'b1,
		draw_n: 1'b1, default: '0};
	localparam crtfb_crt_t CRT_RST = '{hsync_n: 1'b1, vsync_n: 1'b1, default: '0};
	// Largest pixel depth code: 16 bits per pixel
	localparam logic [2:0] DEPTH_MAX = 3'h4;
	// Frame counter bit that blinks the cursor by default
	localparam int BLINK_BIT_DEF = 4;

endpackage

//--- verilog/crtfb_core.sv
// Frame-buffer and CRT timing core: memory cycles, refresh, sync, cursor, light pen.
// Assumes memory answers in step with mcyc and the user holds cfg stable.
// Summary of operation
// - One clock at twice dot rate drives all
// - Memory cycle signal toggles every clock
// - Address then data on bus, strobe marks address
// - Upper pins: address 16-19 or raster 0-3
// - Separate top raster bit, 32-raster rows
// - Select shows graphic or character access
// - Read line sets data bus direction
// - Active-low drawing marker versus refresh
// - Two screen enables: on, off, blanked
// - Two cursors from address, rasters, mode
// - Active-low horizontal and vertical sync
// - Two-way external sync locks timing
// - Strobe captures refresh address, 20 bits
// - 16-bit words, 1 to 16 bits per pixel
// - 2 MB graphic, 128 KB character space
// - 256 words, 32 rasters, 4096 lines
// - 4096 pixels per line at one bit
// - Non-interlaced and two interlace modes
`timescale 1ns/1ps
module crtfb_core #(
	parameter int BLINK_BIT = crtfb_pkg::BLINK_BIT_DEF
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Display setup
	input wire crtfb_pkg::crtfb_cfg_t cfg,
	// Drawing access request and answer
	input wire crtfb_pkg::crtfb_drw_t drw,
	output logic draw_ack,
	output logic [15:0] draw_rdata,
	// Frame-buffer pins
	output crtfb_pkg::crtfb_fb_t fb,
	input wire logic [15:0] mad_i,
	// CRT pins
	output crtfb_pkg::crtfb_crt_t crt,
	// External sync pin
	input wire logic ext_sync_n_i,
	output logic ext_sync_n_o,
	output logic ext_sync_n_oe,
	// Light pen
	input wire logic light_pen_strobe,
	output logic [19:0] lp_addr,
	output logic lp_valid
);

	if (BLINK_BIT < 0 || BLINK_BIT > 4) begin : g_bad_blink
		$error("BLINK_BIT must lie in 0..4");
	end

	crtfb_pkg::crtfb_st_t st_ff;
	crtfb_pkg::crtfb_st_t nxt_st;
	logic [12:0] hdw;
	logic [19:0] addr;
	logic [19:0] step;
	logic act;
	logic lp_rise;
	logic ex_fall;
	logic odd;
	logic vwin;

	// Words shown per line from pixel count and depth
	function automatic logic [12:0] words_per_line(crtfb_pkg::crtfb_cfg_t c);
		logic [2:0] d;
		d = (c.depth > crtfb_pkg::DEPTH_MAX) ? crtfb_pkg::DEPTH_MAX : c.depth;
		return c.hpix >> (crtfb_pkg::DEPTH_MAX - d);
	endfunction

	// Cursor hit for one cursor address
	function automatic logic cur_hit(logic [19:0] a, logic [19:0] ca, logic [4:0] r,
		crtfb_pkg::crtfb_cfg_t c, logic blink);
		logic hit;
		hit = (a == ca) && (r >= c.cur_top) && (r <= c.cur_bot);
		case (c.cur_mode)
			crtfb_pkg::CUR_ON: return hit;
			crtfb_pkg::CUR_BLINK: return hit & blink;
			default: return 1'b0;
		endcase
	endfunction

	// Next state: one memory cycle is two clocks, address then data
	always_comb begin
		nxt_st = st_ff;
		nxt_st.ack = 1'b0;
		nxt_st.lp_valid = 1'b0;
		nxt_st.lp_sync = {st_ff.lp_sync[1:0], light_pen_strobe}; // Two-flop pen synchroniser
		nxt_st.ex_sync = {st_ff.ex_sync[1:0], ext_sync_n_i};
		lp_rise = st_ff.lp_sync[1] & ~st_ff.lp_sync[2];
		ex_fall = ~st_ff.ex_sync[1] & st_ff.ex_sync[2] & ~cfg.sync_drive;
		hdw = words_per_line(cfg);
		act = ({5'h0, st_ff.hcnt} < hdw) && (st_ff.vcnt < cfg.vdisp) &&
			(cfg.scr_a != crtfb_pkg::SCR_OFF || cfg.scr_b != crtfb_pkg::SCR_OFF);
		odd = st_ff.field && (cfg.scan != crtfb_pkg::SCAN_NI);
		vwin = ({1'b0, st_ff.vcnt} >= {1'b0, cfg.vs_start}) &&
			({1'b0, st_ff.vcnt} < ({1'b0, cfg.vs_start} + {9'h0, cfg.vs_width}));
		step = (cfg.scan == crtfb_pkg::SCAN_ISV) ? {7'h0, cfg.mem_width, 1'b0} :
			{8'h0, cfg.mem_width};
		addr = st_ff.ref_addr;
		if (st_ff.fb.mcyc) begin
			// Address phase: close last access, open the next
			nxt_st.fb.mcyc = 1'b0;
			if (st_ff.acc == crtfb_pkg::ACC_DRAW) begin
				nxt_st.ack = 1'b1;
				if (!st_ff.dwr) begin
					nxt_st.rdata = mad_i;
				end
			end
			if (act) begin
				nxt_st.acc = crtfb_pkg::ACC_REF;
				nxt_st.ref_addr = st_ff.ref_addr + 20'h1;
			end else if (drw.valid && st_ff.acc != crtfb_pkg::ACC_DRAW) begin
				nxt_st.acc = crtfb_pkg::ACC_DRAW;
				addr = drw.addr;
				nxt_st.dwr = drw.write;
				nxt_st.dwdata = drw.wdata;
			end else begin
				nxt_st.acc = crtfb_pkg::ACC_IDLE;
			end
			// Character space is 64k words
			if (cfg.chr_mode) begin
				addr[19:16] = 4'h0;
			end
			nxt_st.fb.mad = addr[15:0];
			nxt_st.fb.mad_oe = (nxt_st.acc != crtfb_pkg::ACC_IDLE);
			nxt_st.fb.fb_address_strobe_n = (nxt_st.acc == crtfb_pkg::ACC_IDLE);
			nxt_st.fb.upper_addr_raster_lines = cfg.chr_mode ? st_ff.ras[3:0] :
				addr[19:16];
			nxt_st.fb.raster_bit_top = cfg.chr_mode & st_ff.ras[4];
			nxt_st.fb.chr = cfg.chr_mode;
			nxt_st.fb.mrd = !(nxt_st.acc == crtfb_pkg::ACC_DRAW && drw.write);
			nxt_st.fb.draw_n = (nxt_st.acc != crtfb_pkg::ACC_DRAW);
			// Screen enables and cursors for this refresh word
			nxt_st.crt.screen_enable_a = act && cfg.scr_a == crtfb_pkg::SCR_ON;
			nxt_st.crt.screen_enable_b = act && cfg.scr_b == crtfb_pkg::SCR_ON;
			nxt_st.crt.cursor_out_a = act && cur_hit(st_ff.ref_addr, cfg.cur_a_addr,
				st_ff.ras, cfg, st_ff.frame[BLINK_BIT]);
			nxt_st.crt.cursor_out_b = act && cur_hit(st_ff.ref_addr, cfg.cur_b_addr,
				st_ff.ras, cfg, st_ff.frame[BLINK_BIT]);
			// Horizontal sync window in memory cycles
			nxt_st.crt.hsync_n = !(({1'b0, st_ff.hcnt} >= {1'b0, cfg.hs_start}) &&
				({1'b0, st_ff.hcnt} < ({1'b0, cfg.hs_start} + {1'b0, cfg.hs_width})));
			// Vertical sync moves half a line in the odd field
			if ((!odd && st_ff.hcnt == 8'h0) || (odd && st_ff.hcnt == (cfg.htotal >> 1))) begin
				nxt_st.crt.vsync_n = !vwin;
			end
			// Line and frame advance
			if (st_ff.hcnt == cfg.htotal) begin
				nxt_st.hcnt = 8'h0;
				if (!cfg.chr_mode) begin
					nxt_st.row_addr = st_ff.row_addr + step;
				end else if (st_ff.ras == cfg.row_last) begin
					nxt_st.ras = 5'h0;
					nxt_st.row_addr = st_ff.row_addr + step;
				end else begin
					nxt_st.ras = st_ff.ras + 5'h1;
				end
				if (st_ff.vcnt == cfg.vtotal) begin
					nxt_st.vcnt = 12'h0;
					nxt_st.ras = 5'h0;
					nxt_st.frame = st_ff.frame + 5'h1;
					nxt_st.field = (cfg.scan != crtfb_pkg::SCAN_NI) & ~st_ff.field;
					nxt_st.row_addr = cfg.start_addr;
					if (cfg.scan == crtfb_pkg::SCAN_ISV && nxt_st.field) begin
						nxt_st.row_addr = cfg.start_addr + {8'h0, cfg.mem_width};
					end
				end else begin
					nxt_st.vcnt = st_ff.vcnt + 12'h1;
				end
				nxt_st.ref_addr = nxt_st.row_addr;
			end else begin
				nxt_st.hcnt = st_ff.hcnt + 8'h1;
			end
		end else begin
			// Data phase: drive write data, release bus on reads
			nxt_st.fb.mcyc = 1'b1;
			nxt_st.fb.fb_address_strobe_n = 1'b1;
			case (st_ff.acc)
				crtfb_pkg::ACC_DRAW: begin
					nxt_st.fb.mad = st_ff.dwr ? st_ff.dwdata : st_ff.fb.mad;
					nxt_st.fb.mad_oe = st_ff.dwr;
				end
				default: begin
					nxt_st.fb.mad_oe = 1'b0;
				end
			endcase
		end
		// Falling external sync restarts the frame
		if (ex_fall) begin
			nxt_st.hcnt = 8'h0;
			nxt_st.vcnt = 12'h0;
			nxt_st.ras = 5'h0;
			nxt_st.field = 1'b0;
			nxt_st.row_addr = cfg.start_addr;
			nxt_st.ref_addr = cfg.start_addr;
		end
		// Light-pen capture of the refresh address
		if (lp_rise) begin
			nxt_st.lp_addr = st_ff.ref_addr;
			nxt_st.lp_valid = 1'b1;
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= '0;
			st_ff.fb <= crtfb_pkg::FB_RST;
			st_ff.crt <= crtfb_pkg::CRT_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs
	assign fb = st_ff.fb;
	assign crt = st_ff.crt;
	assign draw_ack = st_ff.ack;
	assign draw_rdata = st_ff.rdata;
	assign lp_addr = st_ff.lp_addr;
	assign lp_valid = st_ff.lp_valid;
	assign ext_sync_n_o = st_ff.crt.vsync_n;
	assign ext_sync_n_oe = cfg.sync_drive;

	// Clocks that horizontal sync has been low
	logic [9:0] hs_low_ff;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hs_low_ff <= 10'h0;
		end else begin
			hs_low_ff <= crt.hsync_n ? 10'h0 : hs_low_ff + 10'h1;
		end
	end

	// Pin checks, all on the operating clock
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	a_mcyc_toggle: assert property (fb.mcyc |=> !fb.mcyc ##1 fb.mcyc)
		else $error("memory cycle did not toggle");
	a_strobe_phase: assert property (!fb.fb_address_strobe_n |->
		!fb.mcyc ##1 fb.fb_address_strobe_n)
		else $error("address strobe outside address phase");
	a_write_dir: assert property (fb.mad_oe && fb.mcyc |-> !fb.mrd && !fb.draw_n)
		else $error("data driven on a read cycle");
	a_draw_cause: assert property ($fell(fb.draw_n) |-> $past(drw.valid))
		else $error("drawing access without request");
	a_ack_after: assert property (draw_ack |-> $past(fb.draw_n, 2) == 1'b0)
		else $error("acknowledge without drawing access");
	a_hsync_width: assert property ($rose(crt.hsync_n) && hs_low_ff < 10'h200 |->
		hs_low_ff == {1'b0, cfg.hs_width, 1'b0})
		else $error("horizontal sync width wrong");
	a_pen_capture: assert property (lp_valid |-> lp_addr == $past(st_ff.ref_addr))
		else $error("light-pen address not captured");
	a_enable_gate: assert property (crt.screen_enable_a && !fb.mcyc |->
		$past(cfg.scr_a) == crtfb_pkg::SCR_ON)
		else $error("screen enable while not shown");
	a_cursor_gate: assert property (crt.cursor_out_a && !fb.mcyc |->
		$past(cfg.cur_mode) != crtfb_pkg::CUR_OFF)
		else $error("cursor shown while off");
	a_raster_top: assert property (!fb.chr |-> !fb.raster_bit_top)
		else $error("top raster bit in graphic mode");

	// Bus pairing: every strobe drives an address, refresh data phases leave the bus
	a_strobe_drive: assert property (!fb.fb_address_strobe_n |-> fb.mad_oe)
		else $error("address strobe with bus released");
	a_refresh_release: assert property (fb.mcyc && fb.draw_n |-> !fb.mad_oe)
		else $error("bus driven in a refresh data phase");

	// Drawing slots: one-clock acknowledge, never two draws in a row, address as asked in graphic mode
	a_draw_gap: assert property (draw_ack |-> fb.draw_n)
		else $error("two drawing accesses back to back");
	a_ack_pulse: assert property (draw_ack |=> !draw_ack)
		else $error("acknowledge longer than one clock");
	a_graphic_upper: assert property (!fb.chr && !fb.fb_address_strobe_n && !fb.draw_n |->
		{fb.upper_addr_raster_lines, fb.mad} == $past(drw.addr))
		else $error("drawing address not on the bus");

	// Select, enables and cursors follow the setup taken at the last address phase
	a_chr_follow: assert property (!fb.mcyc |-> fb.chr == $past(cfg.chr_mode))
		else $error("access select does not follow setup");
	a_enable_blank: assert property (crt.screen_enable_b && !fb.mcyc |->
		$past(cfg.scr_b) == crtfb_pkg::SCR_ON)
		else $error("second screen enable while not shown");
	a_cursor_b_gate: assert property (crt.cursor_out_b && !fb.mcyc |->
		$past(cfg.cur_mode) != crtfb_pkg::CUR_OFF)
		else $error("second cursor shown while off");

	// Vertical sync moves only on address phases
	a_vsync_phase: assert property ($changed(crt.vsync_n) |-> !fb.mcyc)
		else $error("vertical sync moved in a data phase");

	// A falling external sync, when listened to, restarts both counters
	a_sync_restart: assert property ($fell(st_ff.ex_sync[1]) && !cfg.sync_drive |=>
		st_ff.hcnt == 8'h0 && st_ff.vcnt == 12'h0)
		else $error("external sync did not restart the frame");

	// The pen flag is a single-clock pulse
	a_pen_pulse: assert property (lp_valid |=> !lp_valid)
		else $error("light-pen flag longer than one clock");

endmodule // crtfb_core

//--- tb/crtfb_mem_model.sv
// Frame memory model on the far side of the frame-buffer pins.
// Assumes accesses in step with mcyc: address while the strobe is low, data one cycle later.
`timescale 1ns/1ps
module crtfb_mem_model (
	// Clock
	input wire logic ref_clk,
	// Frame-buffer pins
	input wire crtfb_pkg::crtfb_fb_t fb,
	output logic [15:0] mad_i
);
	logic [15:0] mem [logic [19:0]];
	logic [19:0] addr_ff;
	logic rd_ff;

	initial begin
		mad_i = 16'h0;
		rd_ff = 1'b1;
		addr_ff = 20'h0;
	end

	// Latch the address on the strobe, answer reads, store writes on the data phase
	always @(posedge ref_clk) begin
		if (fb.fb_address_strobe_n === 1'b0) begin
			addr_ff = {fb.upper_addr_raster_lines, fb.mad};
			rd_ff = fb.mrd;
			mad_i <= mem.exists(addr_ff) ? mem[addr_ff] : ~addr_ff[15:0];
		end else begin
			if (rd_ff === 1'b0 && fb.mad_oe === 1'b1) begin
				mem[addr_ff] = fb.mad;
			end
			rd_ff = 1'b1;
			mad_i <= ~mad_i; // Released bus never keeps the last word
		end
	end
endmodule // crtfb_mem_model

//--- tb/crtfb_core_tb.sv
// Self-checking bench for the frame-buffer and CRT timing core.
// Assumes the memory model answers reads; expected results are queued by the driver.
`timescale 1ns/1ps
module crtfb_core_tb;
	typedef struct packed {logic write; logic [19:0] addr; logic [15:0] data;} crtfb_note_t;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	crtfb_pkg::crtfb_cfg_t cfg;
	crtfb_pkg::crtfb_drw_t drw;
	crtfb_pkg::crtfb_fb_t fb;
	crtfb_pkg::crtfb_crt_t crt;
	logic draw_ack, lp_valid, light_pen_strobe, ext_drv, sync_o, sync_oe, sync_pin, prev_mcyc;
	logic [15:0] draw_rdata, mad_i;
	logic [19:0] lp_addr;
	logic [19:0] addrs [8];
	logic [15:0] shadow [logic [19:0]];
	crtfb_note_t notes[$];
	int fail_count = 0;
	int tests_run = 0;
	int seed = 32'h7a7267ea;
	int hs_len = 0, vs_len = 0, cur_a = 0, cur_b = 0, en_a = 0, en_b = 0;

	// Clock at 125 MHz
	always #4 ref_clk = ~ref_clk;
	// Pin level: device drives when enabled, else the bench
	assign sync_pin = sync_oe ? sync_o : ext_drv;

	crtfb_core #(.BLINK_BIT(0)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .cfg(cfg), .drw(drw),
		.draw_ack(draw_ack), .draw_rdata(draw_rdata), .fb(fb), .mad_i(mad_i), .crt(crt),
		.ext_sync_n_i(sync_pin), .ext_sync_n_o(sync_o), .ext_sync_n_oe(sync_oe),
		.light_pen_strobe(light_pen_strobe), .lp_addr(lp_addr), .lp_valid(lp_valid));
	crtfb_mem_model i_mem (.ref_clk(ref_clk), .fb(fb), .mad_i(mad_i));

	// Compare a word
	task automatic chk_word(input string name, input logic [19:0] exp, input logic [19:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask

	// Compare a flag
	task automatic chk_bit(input string name, input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %b seen %b", name, exp, got);
		end
	endtask

	// Verdict and end of run
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// One drawing access; valid stays up so a next access may follow at once
	task automatic draw(input logic wr, input logic [19:0] addr, input logic [15:0] data);
		int n = 0;
		notes.push_back({wr, addr, wr ? data : shadow[addr]});
		if (wr) shadow[addr] = data;
		drw <= '{valid: 1'b1, write: wr, addr: addr, wdata: data};
		do @(posedge ref_clk); while (draw_ack !== 1'b1 && ++n < 400);
		if (n >= 400) begin
			chk_bit("draw_ack", 1'b1, 1'b0);
			results();
		end
	endtask

	// Output watcher: takes the oldest note whenever a result shows
	always @(posedge ref_clk) begin
		if (rst_b) begin
			chk_bit("mcyc", ~prev_mcyc, fb.mcyc);
			chk_bit("chr", cfg.chr_mode, fb.chr);
			chk_bit("ext_sync_n_oe", cfg.sync_drive, sync_oe);
			chk_bit("ext_sync_n_o", crt.vsync_n, sync_o);
			if (fb.fb_address_strobe_n === 1'b0 && fb.draw_n === 1'b0) begin
				chk_word("draw address", notes[0].addr, {fb.upper_addr_raster_lines, fb.mad});
				chk_bit("draw mrd", ~notes[0].write, fb.mrd);
			end
			if (fb.fb_address_strobe_n === 1'b0 && fb.draw_n === 1'b1) begin
				chk_bit("refresh mrd", 1'b1, fb.mrd);
			end
			if (draw_ack === 1'b1) begin
				if (!notes[0].write) chk_word("draw_rdata", notes[0].data, draw_rdata);
				void'(notes.pop_front());
			end
			if (crt.hsync_n === 1'b0) hs_len++;
			else if (hs_len > 0) begin
				chk_word("hsync width", 20'(2 * cfg.hs_width), 20'(hs_len));
				hs_len = 0;
			end
			if (crt.vsync_n === 1'b0) vs_len++;
			else if (vs_len > 0) begin
				chk_word("vsync width", 20'(cfg.vs_width * (cfg.htotal + 1) * 2), 20'(vs_len));
				vs_len = 0;
			end
			cur_a += (crt.cursor_out_a === 1'b1);
			cur_b += (crt.cursor_out_b === 1'b1);
			en_a += (crt.screen_enable_a === 1'b1);
			en_b += (crt.screen_enable_b === 1'b1);
		end
		prev_mcyc = rst_b ? fb.mcyc : 1'b0; // mcyc holds high over the first edge after reset
	end

	// Main sequence
	initial begin
		int n;
		cfg = '0;
		drw = '0;
		light_pen_strobe = 1'b0;
		ext_drv = 1'b1;
		prev_mcyc = 1'b1;
		cfg.depth = 3'h4;
		cfg.hpix = 13'h8;
		cfg.htotal = 8'hf;
		cfg.hs_start = 8'ha;
		cfg.hs_width = 8'h3;
		cfg.vdisp = 12'h4;
		cfg.vtotal = 12'h7;
		cfg.vs_start = 12'h5;
		cfg.vs_width = 4'h1;
		cfg.row_last = 5'h7;
		cfg.cur_bot = 5'h1f;
		cfg.mem_width = 12'h8;
		cfg.start_addr = 20'h00100;
		cfg.cur_a_addr = 20'h00100;
		cfg.cur_b_addr = 20'hfffff;
		cfg.cur_mode = crtfb_pkg::CUR_ON;
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge ref_clk);
		// Screens off: back-to-back random writes, then read back
		for (n = 0; n < 8; n++) addrs[n] = 20'($random(seed));
		for (n = 0; n < 8; n++) draw(1'b1, addrs[n], 16'($random(seed)));
		for (n = 7; n >= 0; n--) draw(1'b0, addrs[n], 16'h0);
		drw.valid <= 1'b0;
		// Screens running: draws wait for free slots
		cfg.scr_a <= crtfb_pkg::SCR_ON;
		cfg.scr_b <= crtfb_pkg::SCR_BLANK;
		cfg.sync_drive <= 1'b1;
		repeat (300) @(posedge ref_clk);
		for (n = 0; n < 8; n++) draw(n[0], addrs[n], 16'($random(seed)));
		drw.valid <= 1'b0;
		repeat (800) @(posedge ref_clk);
		chk_bit("screen_enable_a shown", 1'b1, en_a > 0);
		chk_bit("screen_enable_b blanked", 1'b0, en_b > 0);
		chk_bit("cursor_out_a seen", 1'b1, cur_a > 0);
		chk_bit("cursor_out_b seen", 1'b0, cur_b > 0);
		// External sync: pin falls just after a vsync pulse, frame restarts from line 0
		n = 0;
		do @(posedge ref_clk); while (crt.vsync_n !== 1'b0 && ++n < 400);
		do @(posedge ref_clk); while (crt.vsync_n !== 1'b1 && ++n < 800);
		chk_bit("vsync end", 1'b1, crt.vsync_n);
		cfg.sync_drive <= 1'b0;
		ext_drv <= 1'b0;
		// Three clocks to sync, two phases, then five lines of 32 clocks to vsync
		n = 0;
		do @(posedge ref_clk); while (crt.vsync_n !== 1'b0 && ++n < 400);
		chk_word("restart to vsync", 20'ha5, 20'(n));
		ext_drv <= 1'b1;
		// Light pen strobe captures an address; the flag is a one-clock pulse
		light_pen_strobe <= 1'b1;
		n = 0;
		do @(posedge ref_clk); while (lp_valid !== 1'b1 && ++n < 20);
		chk_bit("lp_valid", 1'b1, lp_valid);
		light_pen_strobe <= 1'b0;
		@(posedge ref_clk);
		chk_bit("lp_valid pulse", 1'b0, lp_valid);
		results();
	end
endmodule // crtfb_core_tb
